// ===== rtl/ccr_pkg.sv
// Purpose: Constants for common control registers 3 to 5
// Assumes: 8-bit parallel control port, registers 3 to 5 at addresses 1Bh, A8h and AAh
// Notes:   Field positions and offsets named once here
package ccr_pkg;
    localparam logic [7:0] ADDR_ESTORE_SIG   = 8'h1B;
    localparam logic [7:0] ADDR_LOOP_TXMON   = 8'hA8;
    localparam logic [7:0] ADDR_LIRESET_RXMON = 8'hAA;
    localparam logic [7:0] RESET_VALUE       = 8'h00;
    localparam logic [7:0] LINE_RESET_RX_MONITOR_CTRL_DEFINED_MASK = 8'h9F;
    // Register 3 fields
    localparam int BIT_TX_ESTORE_ENABLE   = 7;
    localparam int BIT_TX_BLOCK_FUNC      = 6;
    localparam int BIT_TX_IDLE_FUNC       = 5;
    localparam int BIT_ESTORE_RESET       = 4;
    localparam int BIT_RX_SIG_REINSERT    = 3;
    localparam int BIT_TX_HW_SIG_INSERT   = 2;
    localparam int BIT_TX_BACKPLANE_CLK   = 1;
    localparam int BIT_CARRIER_LOSS_ALT   = 0;
    // Register 4 fields
    localparam int BIT_REMOTE_LOOP        = 7;
    localparam int BIT_LOCAL_LOOP         = 6;
    localparam int BIT_LINE_ALL_ONES      = 5;
    // Register 5 fields
    localparam int BIT_LINE_IFACE_RESET   = 7;
    localparam int CHAN_SEL_MSB           = 4;
    // Carrier loss zero counts
    localparam logic [11:0] CARRIER_LOSS_ZEROS_STD = 12'h0FF;
    localparam logic [11:0] CARRIER_LOSS_ZEROS_ALT = 12'h800;
endpackage

// ===== rtl/ccr_edge_if.sv
// Purpose: Carries control bits to the edge detector
// Assumes: Single clock domain
// Notes:   Levels in, pulses out
`timescale 1ns/1ps
`default_nettype none
interface ccr_edge_if;
    logic estore_reset;
    logic line_iface_reset;
    logic estore_reset_pulse;
    logic line_iface_reset_pulse;
    modport ctrl (output estore_reset, output line_iface_reset,
                  input estore_reset_pulse, input line_iface_reset_pulse);
    modport det  (input estore_reset, input line_iface_reset,
                  output estore_reset_pulse, output line_iface_reset_pulse);
endinterface
`default_nettype wire

// ===== rtl/ccr_edge_detect.sv
// Purpose: Edge detection of the two reset control bits
// Assumes: Bits already on sys_clk_i
// Notes:   Pulses are one cycle, registered
`timescale 1ns/1ps
`default_nettype none
module ccr_edge_detect (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    ccr_edge_if.det   edge_if
);
    typedef struct packed {
        logic es_prev;
        logic li_prev;
        logic es_pulse;
        logic li_pulse;
    } edge_state_t;

    edge_state_t state_q;
    edge_state_t state_d;

    always_comb begin
        state_d          = state_q;
        state_d.es_prev  = edge_if.estore_reset;
        state_d.li_prev  = edge_if.line_iface_reset;
        // Falling edge only
        state_d.es_pulse = state_q.es_prev & ~edge_if.estore_reset;
        // Rising edge only
        state_d.li_pulse = ~state_q.li_prev & edge_if.line_iface_reset;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign edge_if.estore_reset_pulse     = state_q.es_pulse;
    assign edge_if.line_iface_reset_pulse = state_q.li_pulse;
endmodule // ccr_edge_detect
`default_nettype wire

// ===== rtl/ccr_common_ctrl.sv
// Purpose: Common control registers 3 to 5 on the parallel port
// Assumes: Port strobes synchronous to sys_clk_i, one cycle each
// Notes:   Datapaths steered here live outside this block
`timescale 1ns/1ps
`default_nettype none
module ccr_common_ctrl (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    output logic      [7:0] rd_data_o,
    output logic            tx_estore_enable_o,
    output logic            tx_block_func_select_o,
    output logic            tx_idle_func_select_o,
    output logic            estore_reset_pulse_o,
    output logic            rx_sig_reinsert_enable_o,
    output logic            tx_hw_sig_insert_enable_o,
    output logic            tx_backplane_clk_select_o,
    output logic [11:0]     carrier_loss_zero_count_o,
    output logic            remote_loop_enable_o,
    output logic            local_loop_enable_o,
    output logic            line_all_ones_force_o,
    output logic [4:0]      tx_monitor_chan_select_o,
    output logic [4:0]      rx_monitor_chan_select_o,
    output logic            line_iface_reset_pulse_o
);
    typedef struct packed {
        logic [7:0]  elastic_store_signaling_ctrl;
        logic [7:0]  loopback_tx_monitor_ctrl;
        logic [7:0]  line_reset_rx_monitor_ctrl;
        logic [7:0]  rd_data;
        logic [11:0] cl_count;
        logic        es_pulse;
        logic        li_pulse;
    } ctrl_state_t;

    ctrl_state_t state_q;
    ctrl_state_t state_d;
    ccr_edge_if  edge_if ();

    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input ctrl_state_t s);
        logic [7:0] r;
        r = 8'h00;
        if (a == ccr_pkg::ADDR_ESTORE_SIG) begin
            r = s.elastic_store_signaling_ctrl;
        end else if (a == ccr_pkg::ADDR_LOOP_TXMON) begin
            r = s.loopback_tx_monitor_ctrl;
        end else if (a == ccr_pkg::ADDR_LIRESET_RXMON) begin
            r = s.line_reset_rx_monitor_ctrl & ccr_pkg::LINE_RESET_RX_MONITOR_CTRL_DEFINED_MASK;
        end
        return r;
    endfunction

    ccr_edge_detect u_edge (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .edge_if   (edge_if)
    );

    assign edge_if.estore_reset =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_ESTORE_RESET];
    assign edge_if.line_iface_reset =
        state_q.line_reset_rx_monitor_ctrl[ccr_pkg::BIT_LINE_IFACE_RESET];

    always_comb begin
        state_d = state_q;
        if (wr_en_i) begin
            if (addr_i == ccr_pkg::ADDR_ESTORE_SIG) begin
                state_d.elastic_store_signaling_ctrl = wr_data_i;
            end else if (addr_i == ccr_pkg::ADDR_LOOP_TXMON) begin
                state_d.loopback_tx_monitor_ctrl = wr_data_i;
            end else if (addr_i == ccr_pkg::ADDR_LIRESET_RXMON) begin
                // Unassigned bits stored as zero whatever the host writes
                state_d.line_reset_rx_monitor_ctrl = wr_data_i & ccr_pkg::LINE_RESET_RX_MONITOR_CTRL_DEFINED_MASK;
            end
        end
        // Read has no side effect; unmapped reads give zero
        if (rd_en_i) begin
            state_d.rd_data = read_mux(addr_i, state_q);
        end
        if (state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_CARRIER_LOSS_ALT]) begin
            state_d.cl_count = ccr_pkg::CARRIER_LOSS_ZEROS_ALT;
        end else begin
            state_d.cl_count = ccr_pkg::CARRIER_LOSS_ZEROS_STD;
        end
        state_d.es_pulse = edge_if.estore_reset_pulse;
        state_d.li_pulse = edge_if.line_iface_reset_pulse;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Control outputs straight from the register flops
    assign rd_data_o                 = state_q.rd_data;
    assign tx_estore_enable_o        =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_TX_ESTORE_ENABLE];
    assign tx_block_func_select_o    =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_TX_BLOCK_FUNC];
    assign tx_idle_func_select_o     =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_TX_IDLE_FUNC];
    assign estore_reset_pulse_o      = state_q.es_pulse;
    assign rx_sig_reinsert_enable_o  =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_RX_SIG_REINSERT];
    assign tx_hw_sig_insert_enable_o =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_TX_HW_SIG_INSERT];
    assign tx_backplane_clk_select_o =
        state_q.elastic_store_signaling_ctrl[ccr_pkg::BIT_TX_BACKPLANE_CLK];
    assign carrier_loss_zero_count_o = state_q.cl_count;
    assign remote_loop_enable_o      =
        state_q.loopback_tx_monitor_ctrl[ccr_pkg::BIT_REMOTE_LOOP];
    assign local_loop_enable_o       =
        state_q.loopback_tx_monitor_ctrl[ccr_pkg::BIT_LOCAL_LOOP];
    assign line_all_ones_force_o     =
        state_q.loopback_tx_monitor_ctrl[ccr_pkg::BIT_LINE_ALL_ONES];
    assign tx_monitor_chan_select_o  =
        state_q.loopback_tx_monitor_ctrl[ccr_pkg::CHAN_SEL_MSB:0];
    assign rx_monitor_chan_select_o  =
        state_q.line_reset_rx_monitor_ctrl[ccr_pkg::CHAN_SEL_MSB:0];
    assign line_iface_reset_pulse_o  = state_q.li_pulse;
endmodule // ccr_common_ctrl
`default_nettype wire

// ===== sim/ccr_common_ctrl_chk.sv
// Purpose: Port checks for common control registers 3 to 5
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to ccr_common_ctrl below
`timescale 1ns/1ps
`default_nettype none
module ccr_common_ctrl_chk (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        tx_estore_enable_o,
    input wire logic        estore_reset_pulse_o,
    input wire logic [11:0] carrier_loss_zero_count_o,
    input wire logic        remote_loop_enable_o,
    input wire logic        local_loop_enable_o,
    input wire logic        line_all_ones_force_o,
    input wire logic [4:0]  tx_monitor_chan_select_o,
    input wire logic [4:0]  rx_monitor_chan_select_o,
    input wire logic        line_iface_reset_pulse_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] r4;
    logic       w3;
    logic       w4;
    logic       w5;
    logic       es_clr;
    logic       li_set;
    assign r4 = {remote_loop_enable_o, local_loop_enable_o,
                 line_all_ones_force_o, tx_monitor_chan_select_o};
    assign w3 = wr_en_i && addr_i == ccr_pkg::ADDR_ESTORE_SIG;
    assign w4 = wr_en_i && addr_i == ccr_pkg::ADDR_LOOP_TXMON;
    assign w5 = wr_en_i && addr_i == ccr_pkg::ADDR_LIRESET_RXMON;
    // Only a write can move either reset bit, so pulses trace back to one
    assign es_clr = w3 && !wr_data_i[ccr_pkg::BIT_ESTORE_RESET];
    assign li_set = w5 && wr_data_i[ccr_pkg::BIT_LINE_IFACE_RESET];
    a_tx_estore_enable_write: assert property (
        w3 |=> tx_estore_enable_o == $past(wr_data_i[7])) else $error("tx_estore_enable");
    a_loss_count: assert property (w3 |=> ##1
        carrier_loss_zero_count_o == ($past(wr_data_i[0], 2) ?
        ccr_pkg::CARRIER_LOSS_ZEROS_ALT : ccr_pkg::CARRIER_LOSS_ZEROS_STD))
        else $error("loss count");
    a_reg4_write: assert property (
        w4 |=> r4 == $past(wr_data_i)) else $error("reg4 write");
    a_reg4_hold: assert property (
        !w4 |=> $stable(r4)) else $error("reg4 hold");
    a_rxmon_write: assert property (
        w5 |=> rx_monitor_chan_select_o == $past(wr_data_i[4:0]))
        else $error("rx monitor");
    a_reg4_read: assert property (
        rd_en_i && addr_i == ccr_pkg::ADDR_LOOP_TXMON |=>
        rd_data_o == $past(r4)) else $error("reg4 read");
    a_es_one_cycle: assert property (
        estore_reset_pulse_o |=> !estore_reset_pulse_o) else $error("es");
    a_li_one_cycle: assert property (
        line_iface_reset_pulse_o |=> !line_iface_reset_pulse_o)
        else $error("li");
    a_es_after_clr: assert property (
        estore_reset_pulse_o |-> $past(es_clr, 3)) else $error("es source");
    a_li_after_set: assert property (
        line_iface_reset_pulse_o |-> $past(li_set, 3))
        else $error("li source");
    c_es_pulse: cover property (estore_reset_pulse_o);
    c_li_pulse: cover property (line_iface_reset_pulse_o);
    c_reg4_read: cover property (rd_en_i && addr_i == 8'hA8);
endmodule // ccr_common_ctrl_chk
bind ccr_common_ctrl ccr_common_ctrl_chk u_chk (.sys_clk_i, .rst_n_i,
    .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .tx_estore_enable_o,
    .estore_reset_pulse_o, .carrier_loss_zero_count_o, .remote_loop_enable_o,
    .local_loop_enable_o, .line_all_ones_force_o, .tx_monitor_chan_select_o,
    .rx_monitor_chan_select_o, .line_iface_reset_pulse_o);
`default_nettype wire

// ===== sim/ccr_host_model.sv
// Purpose: Host side of the parallel control port
// Assumes: One-cycle strobes launched 1 ns after the edge
// Notes:   Idle bus shows inverted last value, not stale data
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wr_data_o,
    output logic            wr_en_o,
    output logic            rd_en_o
);
    initial {addr_o, wr_data_o, wr_en_o, rd_en_o} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1 {addr_o, wr_data_o, wr_en_o} = {a, d, 1'b1};
        @(posedge sys_clk_i);
        #1 {addr_o, wr_data_o, wr_en_o} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1 {addr_o, rd_en_o} = {a, 1'b1};
        @(posedge sys_clk_i);
        #1 {addr_o, rd_en_o} = {~a, 1'b0};
        d = rd_data_i;
    endtask
endmodule // ccr_host_model
`default_nettype wire

// ===== sim/ccr_common_ctrl_tb.sv
// Purpose: Register access and control output tests
// Assumes: Host model drives the port 1 ns after each edge
// Notes:   Edge pulses are counted, not timed
`timescale 1ns/1ps
`default_nettype none
module ccr_common_ctrl_tb;
    logic        clk;
    logic        rst_n;
    logic        we;
    logic        re;
    logic        es_p;
    logic        li_p;
    logic [7:0]  addr, wd, rdat, r, x, o3, o4, e3, e4, e5;
    logic [4:0]  rx;
    logic [11:0] cnt;
    logic [7:0]  es_n = 8'h00;
    logic [7:0]  li_n = 8'h00;
    logic [7:0]  ta [6] = '{8'h1B, 8'h1B, 8'hA8, 8'hA8, 8'hAA, 8'h1C};
    logic [7:0]  td [6] = '{8'hEF, 8'h02, 8'hB5, 8'h4A, 8'h1F, 8'hFF};
    int          n_fail = 0;
    int          checks_done = 0;
    assign {o3[4], o3[0]} = 2'b00;
    ccr_host_model host (.sys_clk_i(clk), .rd_data_i(rdat), .addr_o(addr),
        .wr_data_o(wd), .wr_en_o(we), .rd_en_o(re));
    ccr_common_ctrl dut (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
        .wr_data_i(wd), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdat),
        .tx_estore_enable_o(o3[7]), .tx_block_func_select_o(o3[6]),
        .tx_idle_func_select_o(o3[5]), .estore_reset_pulse_o(es_p),
        .rx_sig_reinsert_enable_o(o3[3]), .tx_hw_sig_insert_enable_o(o3[2]),
        .tx_backplane_clk_select_o(o3[1]), .carrier_loss_zero_count_o(cnt),
        .remote_loop_enable_o(o4[7]), .local_loop_enable_o(o4[6]),
        .line_all_ones_force_o(o4[5]), .tx_monitor_chan_select_o(o4[4:0]),
        .rx_monitor_chan_select_o(rx), .line_iface_reset_pulse_o(li_p));
    always @(posedge clk) begin
        es_n <= es_n + 8'(es_p);
        li_n <= li_n + 8'(li_p);
    end
    task automatic check(input logic [23:0] s, input logic [23:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #100000;
        n_fail++;
        test_done;
    end
    initial begin
        {rst_n, e3, e4, e5} = '0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        host.rd(8'h1B, r);
        check(r, 8'h00);
        check(cnt, 12'h0FF);
        for (int i = 0; i < 6; i++) begin
            host.wr(ta[i], td[i]);
            if (ta[i] == 8'h1B) e3 = td[i];
            if (ta[i] == 8'hA8) e4 = td[i];
            if (ta[i] == 8'hAA) e5 = td[i] & 8'h9F;
            host.rd(ta[i], r);
            x = ta[i] == 8'h1B ? e3 : ta[i] == 8'hA8 ? e4 :
                ta[i] == 8'hAA ? e5 : 8'h00;
            check(r, x);
            check({o3, o4, 3'h0, rx}, {e3 & 8'hEE, e4, 3'h0, e5[4:0]});
            check(cnt, e3[0] ? 12'h800 : 12'h0FF);
        end
        host.wr(8'h1B, 8'h10);
        repeat (4) @(posedge clk);
        check(es_n, 8'h00);
        host.wr(8'h1B, 8'h00);
        repeat (4) @(posedge clk);
        check(es_n, 8'h01);
        host.wr(8'hAA, 8'h80);
        host.wr(8'hAA, 8'h80);
        repeat (4) @(posedge clk);
        check(li_n, 8'h01);
        host.wr(8'hAA, 8'h00);
        repeat (4) @(posedge clk);
        check(li_n, 8'h01);
        host.wr(8'hAA, 8'h80);
        repeat (4) @(posedge clk);
        check(li_n, 8'h02);
        // Line data never relied on after its reset, so no recovery wait
        test_done;
    end
endmodule // ccr_common_ctrl_tb
`default_nettype wire
